// File: design/dkic_pkg.sv
// Purpose: Shared constants and types of the drive keypad and input control block
// Assumes: 40 MHz core clock
// Notes: Times in milliseconds, turned into cycles here
package dkic_pkg;

   // Clock rate and derived timing
   localparam int CLK_KHZ = 40000;
   localparam int DEBOUNCE_MS = 20;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_KHZ;
   localparam int REPEAT_FIRST_MS = 500;
   localparam int REPEAT_FIRST_CYCLES = REPEAT_FIRST_MS * CLK_KHZ;
   localparam int REPEAT_SLOW_MS = 250;
   localparam int REPEAT_SLOW_CYCLES = REPEAT_SLOW_MS * CLK_KHZ;
   localparam int REPEAT_FAST_MS = 50;
   localparam int REPEAT_FAST_CYCLES = REPEAT_FAST_MS * CLK_KHZ;
   localparam int FLASH_HALF_MS = 250;
   localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * CLK_KHZ;
   localparam int TIMER_W = 26;
   localparam logic [3:0] REPEAT_SPEEDUP_COUNT = 4'h8;

   // Key positions within the key vector
   localparam int NUM_KEYS = 8;
   localparam int KEY_ESCAPE = 0;
   localparam int KEY_SELECT = 1;
   localparam int KEY_UP = 2;
   localparam int KEY_DOWN = 3;
   localparam int KEY_ENTER = 4;
   localparam int KEY_REVERSE = 5;
   localparam int KEY_START = 6;
   localparam int KEY_STOP = 7;
   localparam logic [7:0] REPEAT_KEYS = 8'h0c;

   // Control source selector values
   localparam logic [3:0] CSRC_THREE_WIRE = 4'h0;
   localparam logic [3:0] CSRC_TWO_WIRE = 4'h1;
   localparam logic [3:0] CSRC_KEYPAD = 4'h2;
   localparam logic [3:0] CSRC_MOMENTARY = 4'h3;
   localparam logic [3:0] CSRC_ACCEL_DECEL = 4'h4;
   localparam logic [3:0] CSRC_ENABLE = 4'h5;
   localparam logic [3:0] CSRC_TERM_SWITCH = 4'h6;
   localparam logic [3:0] CSRC_FREQ_SELECT = 4'h7;
   localparam logic [3:0] CSRC_PRESET = 4'h8;
   localparam logic [3:0] CSRC_PI = 4'h9;
   localparam logic [3:0] RST_CONTROL_SOURCE = 4'h0;

   // Other selector codes
   localparam logic [1:0] FSRC_INTERNAL = 2'h1;
   localparam logic [3:0] RESET_FN_APPLY = 4'h2;
   localparam logic [1:0] STOP_MODE_COAST = 2'h1;

   // Parameter index ranges for the display and program lists
   localparam logic [6:0] DISP_FIRST = 7'h01;
   localparam logic [6:0] DISP_LAST = 7'h13;
   localparam logic [6:0] PROG_FIRST = 7'h1e;
   localparam logic [6:0] PROG_LAST = 7'h54;

   // Keypad panel states, Gray along display, program, edit
   typedef enum logic [1:0] {
      PANEL_DISPLAY = 2'b00,
      PANEL_PROGRAM = 2'b01,
      PANEL_EDIT = 2'b11
   } dkic_panel_e;

   typedef struct packed {
      logic stop;
      logic start;
      logic reverse;
      logic enter;
      logic down;
      logic up;
      logic select;
      logic escape;
   } dkic_keys_s;

   typedef struct packed {
      logic [15:0] accel;
      logic [15:0] decel;
   } dkic_ramp_s;

   typedef struct packed {
      logic [15:0] preset5;
      logic [15:0] preset4;
      logic [15:0] preset1;
      logic [15:0] preset0;
   } dkic_preset_s;

endpackage

// File: design/dkic_pin_sync.sv
// Purpose: Two-stage synchroniser for contact and terminal inputs
// Assumes: Inputs are asynchronous levels
// Notes: Nothing reads the first stage except the second stage
`timescale 1ns/100ps
module dkic_pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Pins
   input wire logic [W-1:0] pinRaw,
   output logic [W-1:0] pinSync
);

   logic [W-1:0] stage1;

   // Two flops against metastability
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= '0;
         pinSync <= '0;
      end else begin
         stage1 <= pinRaw;
         pinSync <= stage1;
      end
   end

endmodule

// File: design/dkic_key_filter.sv
// Purpose: Debounce, press detection and hold repeat for the keypad keys
// Assumes: Raw key levels are asynchronous, high while pressed
// Notes: Repeat accelerates after a fixed number of repeats
`timescale 1ns/100ps
module dkic_key_filter
   import dkic_pkg::*;
#(
   parameter int DEBOUNCE = DEBOUNCE_CYCLES,
   parameter int REP_FIRST = REPEAT_FIRST_CYCLES,
   parameter int REP_SLOW = REPEAT_SLOW_CYCLES,
   parameter int REP_FAST = REPEAT_FAST_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Keys
   input wire logic [NUM_KEYS-1:0] keyRaw,
   output logic [NUM_KEYS-1:0] keyPress
);

   logic [NUM_KEYS-1:0] keySync;

   dkic_pin_sync #(.W(NUM_KEYS)) u_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .pinRaw(keyRaw),
      .pinSync(keySync)
   );

   genvar i;
   for (i = 0; i < NUM_KEYS; i++) begin : g_key
      logic stable;
      logic [TIMER_W-1:0] bounceCnt;
      logic [TIMER_W-1:0] holdCnt;
      logic [TIMER_W-1:0] holdLimit;
      logic [3:0] repeats;
      logic holdFire;

      // Limit depends on repeats so far
      assign holdLimit = (repeats == 4'h0) ? TIMER_W'(REP_FIRST - 1) :
                         (repeats >= REPEAT_SPEEDUP_COUNT) ? TIMER_W'(REP_FAST - 1) : TIMER_W'(REP_SLOW - 1);
      assign holdFire = stable && REPEAT_KEYS[i] && (holdCnt == holdLimit);

      // A level must hold the full debounce time
      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            stable <= 1'b0;
            bounceCnt <= '0;
         end else if (keySync[i] != stable) begin
            if (bounceCnt == TIMER_W'(DEBOUNCE - 1)) begin
               stable <= keySync[i];
               bounceCnt <= '0;
            end else begin
               bounceCnt <= bounceCnt + 1'b1;
            end
         end else begin
            bounceCnt <= '0;
         end
      end

      // Hold timer; only up and down fire from it
      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            holdCnt <= '0;
            repeats <= 4'h0;
         end else if (!stable) begin
            holdCnt <= '0;
            repeats <= 4'h0;
         end else if (holdFire) begin
            holdCnt <= '0;
            repeats <= (repeats >= REPEAT_SPEEDUP_COUNT) ? repeats : repeats + 1'b1;
         end else begin
            holdCnt <= holdCnt + 1'b1;
         end
      end

      // One pulse per debounced press, plus repeat pulses while up or down is held
      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            keyPress[i] <= 1'b0;
         end else begin
            keyPress[i] <= (keySync[i] && !stable && bounceCnt == TIMER_W'(DEBOUNCE - 1)) || holdFire; // RULE24
         end
      end
   end

endmodule

// File: design/dkic_core.sv
// Purpose: Keypad panel, start and direction logic, terminal modes and reference selection
// Assumes: Settings and status on core_clk; pins and keys asynchronous
// Notes: Long times are parameters so a bench can shorten them
//
// Functional notes
// RULE1 - Preset mode ignores analog, uses preset switches
// RULE2 - Aux and low switch pick preset, ramp set
// RULE3 - Preset mode repurposes first, second, aux terminals
// RULE4 - PI mode: aux terminal engages PI control
// RULE5 - Modes 4 to 9: aux activity clears faults
// RULE6 - Frequency source 1 selects internal setpoint
// RULE7 - Keypad starts in display mode
// RULE8 - Display mode views only, never edits
// RULE9 - Escape toggles display and program modes
// RULE10 - Escape during editing cancels the edit
// RULE11 - Select starts editing, indicator flashes
// RULE12 - Up/down step list or value, repeat
// RULE13 - Enter commits value only in program mode
// RULE14 - After commit, indicator steady, not flashing
// RULE15 - One direction indicator lit steady
// RULE16 - Old direction flashes during deceleration
// RULE17 - Reverse key only in keypad mode
// RULE18 - Start key only in keypad mode
// RULE19 - Stop key works in every mode
// RULE20 - Stop key clears a fault halt
// RULE21 - New control source needs reset or power
// RULE22 - Keys accepted only from fitted keypad
// RULE23 - Opening maintained run input stops drive
// RULE24 - Debounced keys, one command per press
`timescale 1ns/100ps
module dkic_core
   import dkic_pkg::*;
#(
   parameter int DEBOUNCE = DEBOUNCE_CYCLES,
   parameter int REP_FIRST = REPEAT_FIRST_CYCLES,
   parameter int REP_SLOW = REPEAT_SLOW_CYCLES,
   parameter int REP_FAST = REPEAT_FAST_CYCLES,
   parameter int FLASH_HALF = FLASH_HALF_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Front keypad
   input wire logic keypadFitted,
   input wire dkic_keys_s keyRaw,
   // Terminal contacts, closed reads high
   input wire logic runFwdTerminal,
   input wire logic runRevTerminal,
   input wire logic presetSwitchLow,
   input wire logic auxControlTerminal,
   // Settings from the parameter store
   input wire logic [3:0] controlSourceSelect,
   input wire logic resetFunctionWrite,
   input wire logic [3:0] resetFunctionSelect,
   input wire logic [1:0] freqSourceSelect,
   input wire logic [1:0] stoppingBehaviourSelect,
   input wire logic [15:0] internalFreqSetpoint,
   input wire logic [15:0] analogFreqRef,
   input wire dkic_preset_s presetFreq,
   input wire dkic_ramp_s rampSetOne,
   input wire dkic_ramp_s rampSetTwo,
   // Drive status
   input wire logic motorRunning,
   input wire logic motorAtZero,
   input wire logic faultActive,
   // Parameter store access
   input wire logic [15:0] paramValue,
   input wire logic paramWritable,
   output logic [6:0] paramIndex,
   output logic [15:0] editValue,
   output logic commitStrobe,
   // Panel indicators
   output dkic_panel_e panelMode,
   output logic programLed,
   output logic fwdLed,
   output logic revLed,
   // Drive commands
   output logic startCmd,
   output logic stopCmd,
   output logic [1:0] stopMode,
   output logic runReverse,
   output logic [15:0] freqRef,
   output dkic_ramp_s rampOut,
   output logic piEnable,
   output logic faultClear,
   output logic analogDisabled,
   output logic [3:0] activeSource
);

   ////////////////////////////////////////////////////////////////////////////
   // Inputs conditioning

   logic [NUM_KEYS-1:0] keyPress;
   logic [4:0] pinSync;
   logic fittedOk;
   logic runFwd, runRev, presetLow, aux, auxLast, runLast;
   logic srcLoaded;
   logic escP, selP, upP, downP, entP, revP, startP, stopP;

   dkic_key_filter #(
      .DEBOUNCE(DEBOUNCE),
      .REP_FIRST(REP_FIRST),
      .REP_SLOW(REP_SLOW),
      .REP_FAST(REP_FAST)
   ) u_keys (
      .core_clk(core_clk),
      .nrst(nrst),
      .keyRaw(keyRaw),
      .keyPress(keyPress)
   );

   dkic_pin_sync #(.W(5)) u_pins (
      .core_clk(core_clk),
      .nrst(nrst),
      .pinRaw({keypadFitted, auxControlTerminal, presetSwitchLow, runRevTerminal, runFwdTerminal}),
      .pinSync(pinSync)
   );

   assign runFwd = pinSync[0];
   assign runRev = pinSync[1];
   assign presetLow = pinSync[2];
   assign aux = pinSync[3];
   assign fittedOk = pinSync[4];

   // A loose or absent keypad produces no commands at all
   assign escP = fittedOk && keyPress[KEY_ESCAPE]; // RULE22
   assign selP = fittedOk && keyPress[KEY_SELECT];
   assign upP = fittedOk && keyPress[KEY_UP];
   assign downP = fittedOk && keyPress[KEY_DOWN];
   assign entP = fittedOk && keyPress[KEY_ENTER];
   assign revP = fittedOk && keyPress[KEY_REVERSE];
   assign startP = fittedOk && keyPress[KEY_START];
   assign stopP = fittedOk && keyPress[KEY_STOP];

   // Mode groups used in several places
   function automatic logic isTwoWire(input logic [3:0] src);
      isTwoWire = (src == CSRC_TWO_WIRE) || (src >= CSRC_ACCEL_DECEL && src <= CSRC_PI);
   endfunction

   function automatic logic auxIsFaultClear(input logic [3:0] src);
      auxIsFaultClear = (src >= CSRC_ACCEL_DECEL) && (src <= CSRC_PI);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Control source latch

   // Loaded after reset or on apply, never from a half-written selector
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         activeSource <= RST_CONTROL_SOURCE;
         srcLoaded <= 1'b0;
      end else begin
         srcLoaded <= 1'b1;
         if (!srcLoaded || (resetFunctionWrite && resetFunctionSelect == RESET_FN_APPLY)) begin
            activeSource <= controlSourceSelect; // RULE21
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Keypad panel

   logic [TIMER_W-1:0] flashCnt;
   logic flashPhase;
   logic [6:0] firstIdx, lastIdx;

   // Blink timer shared by all indicators
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         flashCnt <= '0;
         flashPhase <= 1'b0;
      end else if (flashCnt == TIMER_W'(FLASH_HALF - 1)) begin
         flashCnt <= '0;
         flashPhase <= ~flashPhase;
      end else begin
         flashCnt <= flashCnt + 1'b1;
      end
   end

   assign firstIdx = (panelMode == PANEL_DISPLAY) ? DISP_FIRST : PROG_FIRST;
   assign lastIdx = (panelMode == PANEL_DISPLAY) ? DISP_LAST : PROG_LAST;

   // Panel mode; power-up always lands in display mode
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         panelMode <= PANEL_DISPLAY; // RULE7
      end else begin
         unique case (panelMode)
            PANEL_DISPLAY: begin
               if (escP) begin
                  panelMode <= PANEL_PROGRAM; // RULE9
               end
            end
            PANEL_PROGRAM: begin
               if (escP) begin
                  panelMode <= PANEL_DISPLAY; // RULE9
               end else if (selP && paramWritable) begin
                  panelMode <= PANEL_EDIT; // RULE11
               end
            end
            PANEL_EDIT: begin
               if (escP || entP) begin
                  panelMode <= PANEL_PROGRAM; // RULE10
               end
            end
            default: begin
               panelMode <= PANEL_DISPLAY;
            end
         endcase
      end
   end

   // List stepping wraps inside the range of the current mode
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         paramIndex <= DISP_FIRST;
      end else if (escP && panelMode == PANEL_DISPLAY) begin
         paramIndex <= PROG_FIRST;
      end else if (escP && panelMode == PANEL_PROGRAM) begin
         paramIndex <= DISP_FIRST;
      end else if (panelMode != PANEL_EDIT) begin
         if (upP) begin
            paramIndex <= (paramIndex >= lastIdx) ? firstIdx : paramIndex + 1'b1; // RULE12
         end else if (downP) begin
            paramIndex <= (paramIndex <= firstIdx) ? lastIdx : paramIndex - 1'b1; // RULE12
         end
      end
   end

   // Tracks the store until editing; display never edits
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         editValue <= 16'h0000;
      end else if (panelMode == PANEL_EDIT) begin
         if (upP) begin
            editValue <= editValue + 1'b1; // RULE12
         end else if (downP) begin
            editValue <= editValue - 1'b1; // RULE12
         end
      end else begin
         editValue <= paramValue; // RULE8
      end
   end

   // Commit only from editing, reached via program mode
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         commitStrobe <= 1'b0;
      end else begin
         commitStrobe <= entP && (panelMode == PANEL_EDIT) && !escP; // RULE13
      end
   end

   // Steady in program mode, flashing while editing
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         programLed <= 1'b0;
      end else begin
         unique case (panelMode)
            PANEL_EDIT: programLed <= flashPhase; // RULE11
            PANEL_PROGRAM: programLed <= 1'b1; // RULE14
            default: programLed <= 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start, stop and direction

   logic runLevel;
   logic driveReverse;
   logic keypadCtl;
   logic enableOpen;

   assign runLevel = runFwd || runRev;
   assign keypadCtl = (activeSource == CSRC_KEYPAD);
   assign enableOpen = (activeSource == CSRC_ENABLE) && !aux;

   // Edge history of the run inputs and the auxiliary terminal
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         runLast <= 1'b0;
         auxLast <= 1'b0;
      end else begin
         runLast <= runLevel;
         auxLast <= aux;
      end
   end

   // Outside keypad control only rising run edges start, so a run must be toggled
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         startCmd <= 1'b0;
      end else if (keypadCtl) begin
         startCmd <= startP; // RULE18
      end else if (isTwoWire(activeSource)) begin
         startCmd <= runLevel && !runLast && !enableOpen;
      end else begin
         startCmd <= runLevel && !runLast && aux;
      end
   end

   // Stop key is honoured whatever the control source
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stopCmd <= 1'b0;
      end else begin
         stopCmd <= stopP // RULE19
                    || (isTwoWire(activeSource) && !runLevel && runLast) // RULE23
                    || (enableOpen && auxLast)
                    || (!isTwoWire(activeSource) && !keypadCtl && !aux && auxLast);
      end
   end

   // Open enable forces a coast stop
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stopMode <= 2'h0;
      end else begin
         stopMode <= enableOpen ? STOP_MODE_COAST : stoppingBehaviourSelect; // RULE19
      end
   end

   // Commanded direction; the reverse key is dead outside keypad control
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         runReverse <= 1'b0;
      end else if (keypadCtl) begin
         if (revP) begin
            runReverse <= ~runReverse; // RULE17
         end
      end else if (runLevel) begin
         runReverse <= runRev && !runFwd;
      end
   end

   // Actual direction follows once the motor is at zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         driveReverse <= 1'b0;
      end else if (!motorRunning || motorAtZero) begin
         driveReverse <= runReverse; // RULE17
      end
   end

   // Commanded LED steady, old one flashes while slowing
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fwdLed <= 1'b0;
         revLed <= 1'b0;
      end else if (motorRunning && driveReverse != runReverse) begin
         fwdLed <= runReverse ? flashPhase : 1'b1; // RULE16
         revLed <= runReverse ? 1'b1 : flashPhase; // RULE16
      end else begin
         fwdLed <= !runReverse; // RULE15
         revLed <= runReverse; // RULE15
      end
   end

   // Fault clear from stop key or, in modes 4 to 9, any aux edge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         faultClear <= 1'b0;
      end else begin
         faultClear <= (stopP && faultActive) // RULE20
                       || (auxIsFaultClear(activeSource) && (aux != auxLast)); // RULE5
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference, ramps and PI

   // Preset mode: low and aux terminals pick speed
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         freqRef <= 16'h0000;
         analogDisabled <= 1'b0;
      end else begin
         analogDisabled <= (activeSource == CSRC_PRESET); // RULE1
         if (activeSource == CSRC_PRESET) begin
            unique case ({aux, presetLow}) // RULE2 RULE3
               2'b00: freqRef <= presetFreq.preset0;
               2'b01: freqRef <= presetFreq.preset1;
               2'b10: freqRef <= presetFreq.preset4;
               2'b11: freqRef <= presetFreq.preset5;
            endcase
         end else if (activeSource == CSRC_FREQ_SELECT && aux) begin
            freqRef <= internalFreqSetpoint;
         end else if (activeSource == CSRC_TERM_SWITCH && !aux) begin
            freqRef <= analogFreqRef;
         end else if (freqSourceSelect == FSRC_INTERNAL) begin
            freqRef <= internalFreqSetpoint; // RULE6
         end else begin
            freqRef <= analogFreqRef;
         end
      end
   end

   // In preset and accel/decel modes, aux closed selects the second accel and decel pair
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rampOut <= '0;
      end else if ((activeSource == CSRC_PRESET || activeSource == CSRC_ACCEL_DECEL) && aux) begin
         rampOut <= rampSetTwo; // RULE2
      end else begin
         rampOut <= rampSetOne; // RULE2
      end
   end

   // PI engage follows the aux terminal only in PI mode
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         piEnable <= 1'b0;
      end else begin
         piEnable <= (activeSource == CSRC_PI) && aux; // RULE4
      end
   end

endmodule

// File: sim/dkic_operator.sv
// Purpose: Operator model that presses keypad keys with contact bounce
// Assumes: want is high while a key is meant to be held down
// Notes: Three cycles of bounce, inside the debounce window
`timescale 1ns/100ps
module dkic_operator
   import dkic_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Intent and contacts
   input wire dkic_keys_s want,
   output dkic_keys_s keyRaw
);
////////////////////////////////////////////////////////////
dkic_keys_s prev = '0;
dkic_keys_s old = '0;
logic [1:0] cnt = '0;
// Odd counts show the old contact state, as a real key chatters
always @(posedge core_clk) begin
   if (want != prev) begin
      old <= prev;
      prev <= want;
      cnt <= 2'h3;
   end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
   end
end
assign keyRaw = cnt[0] ? old : prev;
endmodule

// File: sim/dkic_core_asserts.sv
// Purpose: Port checks on the keypad and input control block
// Assumes: One clock, nrst asynchronous and active low
// Notes: Windows allow for sync and debounce
`timescale 1ns/100ps
module dkic_core_asserts
   import dkic_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Inputs watched
   input wire logic [3:0] controlSourceSelect,
   input wire logic resetFunctionWrite,
   input wire logic [3:0] resetFunctionSelect,
   input wire logic faultActive,
   // Outputs watched
   input wire logic commitStrobe,
   input wire dkic_panel_e panelMode,
   input wire logic programLed,
   input wire logic piEnable,
   input wire logic faultClear,
   input wire logic analogDisabled,
   input wire logic [3:0] activeSource
);
////////////////////////////////////////////////////////////
default clocking @(posedge core_clk);
endclocking
default disable iff (!nrst);
// Registered outputs lag their cause by one edge
a_start_display: assert property ($rose(nrst) |-> (panelMode == PANEL_DISPLAY)[*3]) else $error("not in display");
a_preset_no_analog: assert property ($past(activeSource) == CSRC_PRESET |-> analogDisabled) else $error("analog on");
a_pi_only_mode: assert property (piEnable |-> $past(activeSource) == CSRC_PI) else $error("pi outside mode");
a_commit_from_edit: assert property (commitStrobe |-> $past(panelMode) == PANEL_EDIT && panelMode == PANEL_PROGRAM)
   else $error("bad commit");
a_led_steady_after: assert property (commitStrobe |-> ##2 programLed[*8]) else $error("led not steady");
a_source_hold: assert property ($past(nrst) && !(resetFunctionWrite && resetFunctionSelect == RESET_FN_APPLY)
   |=> $stable(activeSource)) else $error("source moved");
a_source_apply: assert property (resetFunctionWrite && resetFunctionSelect == RESET_FN_APPLY
   |=> activeSource == $past(controlSourceSelect)) else $error("source not applied");
a_clear_cause: assert property (faultClear |-> activeSource >= CSRC_ACCEL_DECEL && activeSource <= CSRC_PI || $past(faultActive))
   else $error("stray clear");
c_commit: cover property (commitStrobe);
c_pi: cover property (piEnable);
c_clear: cover property (faultClear);
endmodule
bind dkic_core dkic_core_asserts chk (.*);

// File: sim/tb.sv
// Purpose: Self-checking bench for the keypad and input control block
// Assumes: Short timings; operator model drives keys
// Notes: Pulses are counted, so a missed or doubled command shows
`timescale 1ns/100ps
module tb;
import dkic_pkg::*;
logic core_clk = 0, nrst = 0, keypadFitted = 1, runFwdTerminal = 0, runRevTerminal = 0, presetSwitchLow = 0;
logic auxControlTerminal = 0, resetFunctionWrite = 0, motorRunning = 0, motorAtZero = 0, faultActive = 0;
logic paramWritable = 1, commitStrobe, programLed, fwdLed, revLed, startCmd, stopCmd, runReverse, piEnable;
logic faultClear, analogDisabled;
logic [3:0] controlSourceSelect = 0, resetFunctionSelect = 0, activeSource;
logic [1:0] freqSourceSelect = 0, stoppingBehaviourSelect = 0, stopMode;
logic [15:0] internalFreqSetpoint, analogFreqRef, paramValue, editValue, freqRef;
logic [6:0] paramIndex;
dkic_preset_s presetFreq;
dkic_ramp_s rampSetOne, rampSetTwo, rampOut;
dkic_keys_s want = '0, keyRaw;
dkic_panel_e panelMode;
int n_errors = 0, total_checks = 0, cyc = 0, nStart = 0, nStop = 0, nCommit = 0, nClear = 0, expClr = 0;
logic [1:0] v;
////////////////////////////////////////////////////////////
dkic_core #(.DEBOUNCE(4), .REP_FIRST(20), .REP_SLOW(10), .REP_FAST(5), .FLASH_HALF(4)) uut (.*);
dkic_operator op (.*);
always #12.5 core_clk = ~core_clk;
// Pulse counters and hang guard
always @(posedge core_clk) begin
   cyc <= cyc + 1;
   nStart <= nStart + startCmd;
   nStop <= nStop + stopCmd;
   nCommit <= nCommit + commitStrobe;
   nClear <= nClear + faultClear;
   if (cyc == 3000) begin
      n_errors++;
      stop_test();
   end
end
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   total_checks++;
   if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
   end
endtask
task automatic press(input int k);
   want[k] <= 1'b1;
   repeat (16) @(posedge core_clk);
   want[k] <= 1'b0;
   repeat (16) @(posedge core_clk);
endtask
task automatic setm(input logic [3:0] m);
   controlSourceSelect <= m;
   resetFunctionSelect <= RESET_FN_APPLY;
   resetFunctionWrite <= 1'b1;
   @(posedge core_clk);
   resetFunctionWrite <= 1'b0;
   repeat (6) @(posedge core_clk);
endtask
function automatic logic [15:0] pick(input logic [1:0] s);
   return s[1] ? (s[0] ? presetFreq.preset5 : presetFreq.preset4) : (s[0] ? presetFreq.preset1 : presetFreq.preset0);
endfunction
task automatic stop_test();
   if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
   else
      $display("verification failed");
   $finish;
endtask
// Main sequence: panel, keypad commands, then terminal modes
initial begin
   void'($urandom(32'h03149426));
   presetFreq = {$urandom, $urandom};
   {rampSetOne, rampSetTwo} = {$urandom, $urandom};
   {internalFreqSetpoint, analogFreqRef} = $urandom;
   paramValue = 16'($urandom);
   repeat (20) @(posedge core_clk);
   nrst <= 1'b1;
   repeat (3) @(posedge core_clk);
   press(KEY_SELECT);
   chk(panelMode, PANEL_DISPLAY);
   press(KEY_ENTER);
   chk(nCommit, 0);
   press(KEY_ESCAPE);
   chk(panelMode, PANEL_PROGRAM);
   chk(paramIndex, PROG_FIRST);
   press(KEY_SELECT);
   chk(panelMode, PANEL_EDIT);
   press(KEY_UP);
   chk(editValue, paramValue + 16'h0001);
   press(KEY_ENTER);
   chk(nCommit, 1);
   press(KEY_SELECT);
   press(KEY_ESCAPE);
   chk({panelMode, 8'(nCommit)}, {PANEL_PROGRAM, 8'h01});
   press(KEY_ESCAPE);
   chk(panelMode, PANEL_DISPLAY);
   setm(CSRC_KEYPAD);
   press(KEY_START);
   chk(nStart, 1);
   controlSourceSelect <= CSRC_TWO_WIRE;
   press(KEY_REVERSE);
   chk(activeSource, CSRC_KEYPAD);
   chk({runReverse, revLed, fwdLed}, 3'h6);
   setm(CSRC_TWO_WIRE);
   press(KEY_START);
   chk(nStart, 1);
   press(KEY_STOP);
   chk(nStop, 1);
   faultActive <= 1'b1;
   press(KEY_STOP);
   chk(nClear, 1);
   keypadFitted <= 1'b0;
   press(KEY_STOP);
   chk(nStop, 2);
   keypadFitted <= 1'b1;
   expClr = 1;
   setm(CSRC_PRESET);
   for (int i = 0; i < 10; i++) begin
      v = (i < 4) ? 2'(i) : 2'($urandom);
      expClr += int'(v[1] != auxControlTerminal);
      {auxControlTerminal, presetSwitchLow} <= v;
      repeat (6) @(posedge core_clk);
      chk({analogDisabled, freqRef}, {1'b1, pick(v)});
      chk(rampOut, v[1] ? rampSetTwo : rampSetOne);
   end
   setm(CSRC_PI);
   expClr += int'(!auxControlTerminal);
   auxControlTerminal <= 1'b1;
   repeat (6) @(posedge core_clk);
   chk(piEnable, 1);
   chk(nClear, expClr);
   setm(CSRC_TWO_WIRE);
   freqSourceSelect <= FSRC_INTERNAL;
   repeat (6) @(posedge core_clk);
   chk(freqRef, internalFreqSetpoint);
   stop_test();
end
endmodule
